// File: design/can_gcs_pkg.sv
// Purpose: Shared constants and types of the CAN global control/status block
// Assumes: APB slave, 32-bit data, one aligned word per byte-wide register
// Notes:   Offsets are byte addresses on the 8-bit APB address
package can_gcs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_FLAGS   = 8'h08;
  localparam logic [7:0] OFF_ENABLE  = 8'h0C;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLE  = 8'h00;

  // General control fields
  localparam int CTL_ABORT    = 7;
  localparam int CTL_OVLREQ   = 6;
  localparam int CTL_TTMODE   = 5;
  localparam int CTL_TTSYNC   = 4;
  localparam int CTL_LISTEN   = 3;
  localparam int CTL_TEST     = 2;
  localparam int CTL_RUN      = 1;
  localparam int CTL_SOFTRST  = 0;

  // General status fields
  localparam int STA_OVERLOAD = 6;
  localparam int STA_TXBUSY   = 4;
  localparam int STA_RXBUSY   = 3;
  localparam int STA_RUN      = 2;
  localparam int STA_BUSOFF   = 1;
  localparam int STA_ERRPASS  = 0;

  // Interrupt flag fields
  localparam int FLG_SUMMARY  = 7;
  localparam int FLG_BUSOFF   = 6;
  localparam int FLG_TWRAP    = 5;
  localparam int FLG_BUFDONE  = 4;
  localparam int FLG_STUFF    = 3;
  localparam int FLG_CRC      = 2;
  localparam int FLG_FORM     = 1;
  localparam int FLG_ACK      = 0;

  // Interrupt enable fields
  localparam int IEN_GLOBAL   = 7;
  localparam int IEN_BUSOFF   = 6;
  localparam int IEN_RX       = 5;
  localparam int IEN_TX       = 4;
  localparam int IEN_MOBERR   = 3;
  localparam int IEN_BUFFER   = 2;
  localparam int IEN_GENERR   = 1;
  localparam int IEN_TWRAP    = 0;

  // Recessive bits needed before the channel goes live
  localparam logic [3:0]  IDLE_BITS  = 4'hB;
  localparam logic [15:0] TIMER_MAX  = 16'hFFFF;

  typedef enum logic [1:0] {ST_OFF, ST_WAIT_IDLE, ST_RUN, ST_STOPPING} run_state_t;

endpackage : can_gcs_pkg

// File: design/can_global_ctrl.sv
// Purpose: Global control, status and interrupt flags of a CAN controller
// Assumes: Protocol engine inputs are synchronous to mclk; bitSample marks a bus bit
// Notes:   APB answers with one wait state; registers sit in the low byte
//
// Summary of operation
// - Abort bit held high clears all in-use bits and cancels pending transfers.
// - Overload request bit asks for an overload frame after next received frame.
// - Time-trigger mode captures timer on SOF or last EOF bit by sync select.
// - Standby ends ongoing transmit, then freezes, drives recessive, disables receiver.
// - Enable mode reached only after eleven consecutive recessive bits.
// - Run-state status shows the real enabled state, not the command.
// - Soft reset bit resets the controller, ORed with hardware reset, self-clears.
// - Overload status is one while requested overload frame is sent; no interrupt.
// - Transmitter-busy status follows any transmit activity; no interrupt.
// - Receiver-busy status follows any frame receive or monitor; no interrupt.
// - Bus-off and error-passive bits show fault state; only bus-off entry interrupts.
// - Summary bit ORs every interrupt source except timer wrap.
// - Bus-off flag set only moving from error-passive to bus-off; write one clears.
// - Timer wrap flag set on FFFF to zero; cleared by write one or handler.
// - Buffer flag set on buffer completion; clear only after all fields rewritten.
// - Stuff error flag set on stuff violation; write one clears.
// - CRC error flag set on CRC mismatch; write one clears.
// - Form error flag set on fixed-form violation; write one clears.
// - Acknowledge error flag set on missing dominant ack; write one clears.
// - Enable bit 7 gates all but timer wrap; bits 6 and 5 bus-off, receive.
// - Enable bits 4..0 cover transmit, object error, buffer, general error, timer.
// - Errors recorded in a message object never set general error flags.
// - The 16-bit timer starts from zero when the controller becomes enabled.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module can_global_ctrl
  import can_gcs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bitSample,
  input  wire logic        canRxBit,
  input  wire logic        txActiveIn,
  input  wire logic        rxActiveIn,
  input  wire logic        overloadSending,
  input  wire logic        busOffIn,
  input  wire logic        errPassiveIn,
  input  wire logic        sofEvent,
  input  wire logic        eofLastBitEvent,
  input  wire logic        timerTick,
  input  wire logic        stuffErrEvt,
  input  wire logic        crcErrEvt,
  input  wire logic        formErrEvt,
  input  wire logic        ackErrEvt,
  input  wire logic        errAtMob,
  input  wire logic        bufferDoneEvt,
  input  wire logic        bufferRewritten,
  input  wire logic        rxIrqPending,
  input  wire logic        txIrqPending,
  input  wire logic        mobErrIrqPending,
  input  wire logic        timerIrqAck,
  output logic             clearInUse,
  output logic             overloadFrameReq,
  output logic             listenMode,
  output logic             testMode,
  output logic             configFreeze,
  output logic             txForceRecessive,
  output logic             rxEnable,
  output logic             ctrlReset,
  output logic             runState,
  output logic [15:0]      canTimer,
  output logic [15:0]      captureTime,
  output logic             captureStrobe,
  output logic             irqGeneral,
  output logic             irqTimerWrap
);

  typedef struct packed {
    run_state_t  state;
    logic [3:0]  idleCnt;
    logic [7:0]  ctrl;
    logic [6:0]  flags;
    logic [7:0]  ien;
    logic [6:0]  stat;
    logic        prevErrPassive;
    logic [15:0] timer;
    logic [15:0] capture;
    logic        capStrobe;
    logic        softRst;
    logic        summary;
    logic        irqGen;
    logic        irqTmr;
    logic        ready;
    logic        slvErr;
    logic [31:0] rdata;
  } regs_t;

  regs_t s;
  regs_t next_s;

  logic       accSetup;
  logic       accDone;
  logic       wrDone;
  logic [6:0] flagSet;
  logic [6:0] flagClr;
  logic       mapped;

  // Bus phase decode; a write lands only on the edge that sees pready high
  assign accSetup = psel && penable && !s.ready;
  assign accDone  = psel && penable && s.ready;
  assign wrDone   = accDone && pwrite && !s.slvErr;
  assign mapped   = (paddr == OFF_CONTROL) || (paddr == OFF_STATUS) ||
                    (paddr == OFF_FLAGS) || (paddr == OFF_ENABLE);

  // Hardware events per flag; message-object errors stay out of general flags
  always_comb
  begin
    flagSet = '0;
    flagSet[FLG_BUSOFF]  = busOffIn && !s.stat[STA_BUSOFF] && s.prevErrPassive;
    flagSet[FLG_TWRAP]   = s.stat[STA_RUN] && timerTick && (s.timer == TIMER_MAX);
    flagSet[FLG_BUFDONE] = bufferDoneEvt;
    flagSet[FLG_STUFF]   = stuffErrEvt && !errAtMob;
    flagSet[FLG_CRC]     = crcErrEvt && !errAtMob;
    flagSet[FLG_FORM]    = formErrEvt && !errAtMob;
    flagSet[FLG_ACK]     = ackErrEvt && !errAtMob;
    flagClr = '0;
    if (wrDone && paddr == OFF_FLAGS)
    begin
      flagClr = pwdata[6:0];
      flagClr[FLG_BUFDONE] = pwdata[FLG_BUFDONE] && bufferRewritten;
    end
    if (timerIrqAck)
    begin
      flagClr[FLG_TWRAP] = 1'b1;
    end
  end

  // All next-state logic in one place
  always_comb
  begin
    next_s = s;
    // Controller reset lasts one cycle and clears stored fields; mirrors, flag events, captures, irq lines and ticks on the old timer count still land
    if (s.softRst)
    begin
      next_s = '0;
    end
    next_s.softRst   = 1'b0;
    next_s.capStrobe = 1'b0;

    // Live status mirrors; only bus-off and error-passive feed an interrupt, through bus-off entry
    next_s.stat[STA_OVERLOAD] = overloadSending;
    next_s.stat[STA_TXBUSY]   = txActiveIn;
    next_s.stat[STA_RXBUSY]   = rxActiveIn;
    next_s.stat[STA_BUSOFF]   = busOffIn;
    next_s.stat[STA_ERRPASS]  = errPassiveIn;
    next_s.stat[5]            = 1'b0;
    next_s.prevErrPassive     = errPassiveIn;

    // Set wins over a same-cycle clear
    next_s.flags = flagSet | (next_s.flags & ~flagClr);

    // Run/standby sequencing; the command bit only requests
    case (s.state)
      ST_OFF:
      begin
        next_s.idleCnt = '0;
        if (s.ctrl[CTL_RUN])
        begin
          next_s.state = ST_WAIT_IDLE;
        end
      end
      ST_WAIT_IDLE:
      begin
        if (!s.ctrl[CTL_RUN])
        begin
          next_s.state = ST_OFF;
        end
        else if (bitSample)
        begin
          if (!canRxBit)
          begin
            next_s.idleCnt = '0;
          end
          else if (s.idleCnt == IDLE_BITS - 4'h1)
          begin
            next_s.state = ST_RUN;
          end
          else
          begin
            next_s.idleCnt = s.idleCnt + 4'h1;
          end
        end
      end
      ST_RUN:
      begin
        if (!s.ctrl[CTL_RUN])
        begin
          next_s.state = ST_STOPPING;
        end
      end
      ST_STOPPING:
      begin
        // Let the frame on the wire finish before freezing
        if (!txActiveIn)
        begin
          next_s.state = ST_OFF;
        end
      end
      default:
      begin
        next_s.state = ST_OFF;
      end
    endcase
    if (s.softRst)
    begin
      next_s.state = ST_OFF;
    end
    next_s.stat[STA_RUN] = (next_s.state == ST_RUN) || (next_s.state == ST_STOPPING);

    // Timer held at zero until enabled, so it restarts from zero each time
    if (s.state == ST_RUN || s.state == ST_STOPPING)
    begin
      if (timerTick)
      begin
        next_s.timer = s.timer + 16'h0001;
      end
    end
    else
    begin
      next_s.timer = '0;
    end

    // Trigger capture only in time-trigger mode
    if (s.ctrl[CTL_TTMODE] && s.stat[STA_RUN])
    begin
      if ((!s.ctrl[CTL_TTSYNC] && sofEvent) || (s.ctrl[CTL_TTSYNC] && eofLastBitEvent))
      begin
        next_s.capture   = s.timer;
        next_s.capStrobe = 1'b1;
      end
    end

    // Register writes; soft reset bit is a one-shot and never stored
    if (wrDone && paddr == OFF_CONTROL)
    begin
      next_s.ctrl                = pwdata[7:0];
      next_s.ctrl[CTL_SOFTRST]   = 1'b0;
      next_s.softRst             = pwdata[CTL_SOFTRST];
    end
    if (wrDone && paddr == OFF_ENABLE)
    begin
      next_s.ien = pwdata[7:0];
    end

    // Summary image and the two request lines
    next_s.summary = (|next_s.flags[FLG_BUSOFF:FLG_ACK] & ~next_s.flags[FLG_TWRAP]) |
                     (|{next_s.flags[FLG_BUSOFF], next_s.flags[FLG_BUFDONE:FLG_ACK]}) |
                     rxIrqPending | txIrqPending | mobErrIrqPending;
    next_s.irqGen = s.ien[IEN_GLOBAL] && (
                    (s.flags[FLG_BUSOFF] && s.ien[IEN_BUSOFF]) ||
                    (rxIrqPending && s.ien[IEN_RX]) ||
                    (txIrqPending && s.ien[IEN_TX]) ||
                    (mobErrIrqPending && s.ien[IEN_MOBERR]) ||
                    (s.flags[FLG_BUFDONE] && s.ien[IEN_BUFFER]) ||
                    (|s.flags[FLG_STUFF:FLG_ACK] && s.ien[IEN_GENERR]));
    next_s.irqTmr = s.flags[FLG_TWRAP] && s.ien[IEN_TWRAP];

    // APB answer one cycle into the access phase
    next_s.ready  = accSetup;
    next_s.slvErr = accSetup && !mapped;
    if (accSetup)
    begin
      case (paddr)
        OFF_CONTROL: next_s.rdata = {24'h00_0000, s.ctrl};
        OFF_STATUS:  next_s.rdata = {24'h00_0000, 1'b0, s.stat};
        OFF_FLAGS:   next_s.rdata = {24'h00_0000, s.summary, s.flags};
        OFF_ENABLE:  next_s.rdata = {24'h00_0000, s.ien};
        default:     next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign prdata           = s.rdata;
  assign pready           = s.ready;
  assign pslverr          = s.slvErr;
  assign clearInUse       = s.ctrl[CTL_ABORT];
  assign overloadFrameReq = s.ctrl[CTL_OVLREQ];
  assign listenMode       = s.ctrl[CTL_LISTEN];
  assign testMode         = s.ctrl[CTL_TEST];
  assign configFreeze     = !s.stat[STA_RUN];
  assign txForceRecessive = !s.stat[STA_RUN];
  assign rxEnable         = s.stat[STA_RUN];
  assign ctrlReset        = s.softRst;
  assign runState         = s.stat[STA_RUN];
  assign canTimer         = s.timer;
  assign captureTime      = s.capture;
  assign captureStrobe    = s.capStrobe;
  assign irqGeneral       = s.irqGen;
  assign irqTimerWrap     = s.irqTmr;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Going live needs the eleventh recessive bit just seen
  property p_run_after_idle;
    (s.state == ST_WAIT_IDLE) && (next_s.state == ST_RUN) |->
      bitSample && canRxBit && s.idleCnt == 4'hA && s.ctrl[CTL_RUN];
  endproperty
  a_run_after_idle: assert property (p_run_after_idle) else $error("enabled early");

  property p_run_status;
    s.state == ST_WAIT_IDLE ##1 s.state == ST_RUN |-> ##1 runState;
  endproperty
  a_run_status: assert property (p_run_status) else $error("run status stale");

  property p_stop_after_tx;
    s.state == ST_STOPPING && txActiveIn |=> !configFreeze;
  endproperty
  a_stop_after_tx: assert property (p_stop_after_tx) else $error("froze mid frame");

  property p_soft_reset;
    wrDone && paddr == OFF_CONTROL && pwdata[0] |=> ctrlReset ##1 (!ctrlReset && s.ctrl == 8'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

  property p_stuff_general;
    stuffErrEvt && !errAtMob && !s.softRst |=> s.flags[FLG_STUFF];
  endproperty
  a_stuff_general: assert property (p_stuff_general) else $error("stuff flag lost");

  property p_mob_err_kept_out;
    !s.flags[FLG_CRC] && !s.softRst && (errAtMob || !crcErrEvt) |=> !s.flags[FLG_CRC];
  endproperty
  a_mob_err_kept_out: assert property (p_mob_err_kept_out) else $error("crc flag leak");

  property p_w1c_zero;
    wrDone && paddr == OFF_FLAGS && !pwdata[FLG_ACK] && s.flags[FLG_ACK] && !s.softRst
      |=> s.flags[FLG_ACK];
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("ack flag lost");

  property p_buffer_hold;
    wrDone && paddr == OFF_FLAGS && !bufferRewritten && s.flags[FLG_BUFDONE] && !s.softRst
      |=> s.flags[FLG_BUFDONE];
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("buffer flag cleared");

  property p_busoff_entry;
    busOffIn && !s.stat[STA_BUSOFF] && s.prevErrPassive && !s.softRst |=> s.flags[FLG_BUSOFF];
  endproperty
  a_busoff_entry: assert property (p_busoff_entry) else $error("bus-off irq missed");

  property p_timer_wrap;
    s.state == ST_RUN && timerTick && s.timer == 16'hFFFF && !s.softRst
      |=> s.timer == 16'h0000 && s.flags[FLG_TWRAP] ##1 irqTimerWrap == s.ien[IEN_TWRAP];
  endproperty
  a_timer_wrap: assert property (p_timer_wrap) else $error("timer wrap wrong");

  property p_timer_idle;
    !runState |=> canTimer == 16'h0000;
  endproperty
  a_timer_idle: assert property (p_timer_idle) else $error("timer ran while off");

  property p_global_gate;
    !s.ien[IEN_GLOBAL] |=> !irqGeneral;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("irq not gated");

  c_enabled:   cover property (s.state == ST_WAIT_IDLE ##1 s.state == ST_RUN);
  c_busoff:    cover property ($rose(s.flags[FLG_BUSOFF]));
  c_wrap:      cover property ($rose(s.flags[FLG_TWRAP]));
  c_standby:   cover property (s.state == ST_STOPPING ##1 s.state == ST_OFF);

endmodule : can_global_ctrl

// File: tb/can_bus_model.sv
// Purpose: Bus-side stand-in that hands sampled CAN bits to the block
// Assumes: Idle bus reads recessive through the termination
// Notes:   One sample every five clocks; dominant only while asked for
`timescale 1ns/1ps
module can_bus_model
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic domReq,
  output logic      bitSample,
  output logic      canRxBit
);
  logic [2:0] phase;

  // Bit divider; no node pulling means a recessive level
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase     <= 3'h0;
      bitSample <= 1'b0;
      canRxBit  <= 1'b1;
    end
    else
    begin
      phase     <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
      bitSample <= (phase == 3'h4);
      canRxBit  <= ~domReq;
    end
  end
endmodule : can_bus_model

// File: tb/can_global_ctrl_tb.sv
// Purpose: Self-checking bench of the CAN global control and status block
// Assumes: APB answers with wait states; bus model samples every 5 clocks
// Notes:   Timer wrap takes a full 16-bit count, so the run is long
`timescale 1ns/1ps
module can_global_ctrl_tb;
  import can_gcs_pkg::*;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, e;
  logic        domReq, bitSample, canRxBit, errAtMob, bd, bufRw, tick, tAck, sof;
  logic        clearInUse, overloadFrameReq, listenMode, testMode, configFreeze;
  logic        txForceRecessive, rxEnable, ctrlReset, runState, irqGeneral, irqTimerWrap;
  logic        run, cs, captureStrobe;
  logic [2:0]  pend;
  logic [3:0]  ev, k;
  logic [4:0]  st;
  logic [7:0]  paddr, ef, en, m;
  logic [15:0] canTimer, captureTime, cp, tm;
  logic [31:0] pwdata, prdata, seed, r;
  int          n_errors, check_count;
  int          cyc = 0;

  can_global_ctrl uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bitSample(bitSample), .canRxBit(canRxBit), .txActiveIn(st[3]),
    .rxActiveIn(st[2]), .overloadSending(st[4]), .busOffIn(st[1]), .errPassiveIn(st[0]),
    .sofEvent(sof), .eofLastBitEvent(bd), .timerTick(tick), .stuffErrEvt(ev[3]),
    .crcErrEvt(ev[2]), .formErrEvt(ev[1]), .ackErrEvt(ev[0]), .errAtMob(errAtMob),
    .bufferDoneEvt(bd), .bufferRewritten(bufRw), .rxIrqPending(pend[2]),
    .txIrqPending(pend[1]), .mobErrIrqPending(pend[0]), .timerIrqAck(tAck),
    .clearInUse(clearInUse), .overloadFrameReq(overloadFrameReq), .listenMode(listenMode),
    .testMode(testMode), .configFreeze(configFreeze), .txForceRecessive(txForceRecessive),
    .rxEnable(rxEnable), .ctrlReset(ctrlReset), .runState(runState), .canTimer(canTimer),
    .captureTime(captureTime), .captureStrobe(captureStrobe), .irqGeneral(irqGeneral),
    .irqTimerWrap(irqTimerWrap));

  can_bus_model bus (.mclk(mclk), .reset_n(reset_n), .domReq(domReq),
    .bitSample(bitSample), .canRxBit(canRxBit));

  // Free-running 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Hang guard, ceiling well above the timer wrap run
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 80000)
    begin
      n_errors++;
      conclude();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Summary excludes the timer wrap flag but sees object pendings
  function automatic logic [7:0] flagExp();
    return {|{ef[6], ef[4:0], pend}, ef[6:0]};
  endfunction : flagExp

  function automatic logic irqExp();
    return en[7] & |{ef[6] & en[6], pend & en[5:3], ef[4] & en[2], |ef[3:0] & en[1]};
  endfunction : irqExp

  task automatic conclude();
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h00_0000, x});
  endtask : rd

  // Sets the bus level, then counts n samples taken at that level
  task automatic bits(input int n, input logic d);
    int c;
    c = 0;
    @(posedge mclk);
    domReq <= d;
    @(posedge mclk);
    while (c < n)
    begin
      @(negedge mclk);
      if (bitSample === 1'b1)
        c++;
    end
  endtask : bits

  // Main sequence
  initial
  begin
    {reset_n, psel, penable, pwrite, domReq, errAtMob, bd, bufRw, tick, tAck, sof} = '0;
    {paddr, pwdata, st, pend, ev, ef, en, m, run, cp, tm} = '0;
    seed = 32'h0001_2C0C;
    n_errors = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFF_CONTROL, RST_CONTROL);
    rd(OFF_STATUS, 8'h00);
    rd(OFF_FLAGS, RST_FLAGS);
    rd(OFF_ENABLE, RST_ENABLE);
    chk(32'(configFreeze), 32'h1);
    apb(1'b1, 8'h10, 8'hFF);
    chk(32'(e), 32'h1);
    apb(1'b1, OFF_STATUS, 8'hFF);
    rd(OFF_STATUS, 8'h00);
    // Dominant bit restarts the recessive count
    apb(1'b1, OFF_CONTROL, 8'h02);
    bits(10, 1'b0);
    bits(1, 1'b1);
    bits(10, 1'b0);
    repeat (3) @(negedge mclk);
    chk(32'(runState), 32'h0);
    bits(1, 1'b0);
    repeat (1) @(negedge mclk);
    chk(32'({runState, rxEnable, configFreeze, txForceRecessive}), 32'hC);
    chk(32'(canTimer), 32'h0);
    run = 1'b1;
    // Timer wrap; summary must ignore it
    apb(1'b1, OFF_ENABLE, 8'h81);
    tick <= 1'b1;
    repeat (65535) @(posedge mclk);
    tick <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(32'({canTimer, irqTimerWrap}), 32'h1_FFFE);
    @(posedge mclk);
    tick <= 1'b1;
    @(posedge mclk);
    tick <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(32'({irqTimerWrap, irqGeneral}), 32'h2);
    rd(OFF_FLAGS, 8'h20);
    @(posedge mclk);
    tAck <= 1'b1;
    @(posedge mclk);
    tAck <= 1'b0;
    rd(OFF_FLAGS, 8'h00);
    // Random traffic on control, events, status and clears
    repeat (20)
    begin
      seed = xs(seed);
      r = seed;
      en = r[23:16];
      m = (r[31:24] & 8'hFA) | 8'h02;
      apb(1'b1, OFF_ENABLE, en);
      rd(OFF_ENABLE, en);
      apb(1'b1, OFF_CONTROL, m);
      rd(OFF_CONTROL, m);
      chk(32'({clearInUse, overloadFrameReq, listenMode, testMode}), 32'({m[7:6], m[3:2]}));
      r = seed;
      @(posedge mclk);
      ef[6] = ef[6] | (r[1] & ~st[1] & st[0]);
      ef[3:0] = ef[3:0] | (r[9] ? 4'h0 : r[13:10]);
      ef[4] = ef[4] | r[14];
      st <= r[4:0];
      pend <= r[7:5];
      bufRw <= r[8];
      errAtMob <= r[9];
      ev <= r[13:10];
      bd <= r[14];
      sof <= r[15];
      tick <= r[16];
      // Capture takes the timer value before this tick lands
      cs = m[5] & (m[4] ? r[14] : r[15]);
      cp = cs ? tm : cp;
      tm = tm + 16'(r[16]);
      @(posedge mclk);
      ev <= 4'h0;
      bd <= 1'b0;
      sof <= 1'b0;
      tick <= 1'b0;
      @(negedge mclk);
      chk(32'({captureStrobe, captureTime}), 32'({cs, cp}));
      chk(32'(canTimer), 32'(tm));
      rd(OFF_FLAGS, flagExp());
      rd(OFF_STATUS, {1'b0, st[4], 1'b0, st[3:2], run, st[1:0]});
      chk(32'(irqGeneral), 32'(irqExp()));
      seed = xs(seed);
      m = seed[7:0];
      apb(1'b1, OFF_FLAGS, m);
      ef = ef & ~(m & (bufRw ? 8'h7F : 8'h6F));
    end
    // Standby waits for the transmitter to go quiet
    @(posedge mclk);
    st <= 5'h08;
    pend <= 3'h0;
    // Abort first, receiver idle, then standby
    apb(1'b1, OFF_CONTROL, 8'h82);
    rd(OFF_CONTROL, 8'h82);
    chk(32'(clearInUse), 32'h1);
    apb(1'b1, OFF_CONTROL, 8'h00);
    repeat (6) @(negedge mclk);
    chk(32'(runState), 32'h1);
    @(posedge mclk);
    st <= 5'h00;
    repeat (4) @(negedge mclk);
    chk(32'({runState, rxEnable, configFreeze, txForceRecessive}), 32'h3);
    // Soft reset pulses once and clears the registers
    apb(1'b1, OFF_ENABLE, 8'hFF);
    apb(1'b1, OFF_CONTROL, 8'h01);
    k = 4'h0;
    repeat (6)
    begin
      @(negedge mclk);
      k = k + 4'(ctrlReset);
    end
    chk(32'(k), 32'h1);
    rd(OFF_CONTROL, 8'h00);
    rd(OFF_ENABLE, 8'h00);
    conclude();
  end
endmodule : can_global_ctrl_tb
